// File: hdl/pbpm_regs.sv
// Bridge power-management register bank with secondary bus power and clock control
// Overview of operation
// - A 16-bit power control and status register is the main power-management interface.
// - That register sits at configuration offset 6C-6D and is also reachable from the local core bus.
// - Bit 15, the wake-event flag, is read-only zero.
// - Bit 8, the wake-event enable, is read-only zero.
// - Bits 1:0 hold the power state, read for the current state and written to request a new one.
// - Only D0 and D3hot are supported.
// - Writes of 01 or 10 to the power-state field are discarded.
// - Such a write still completes normally with no error.
// - A change between D0 and D3hot raises a non-maskable interrupt to the local core.
// - An 8-bit bridge support register sits at offset 6E with bits 5:0 reserved zero, also reachable locally.
// - Bit 7 of the bridge support register lets the power state govern the secondary bus and resets to zero.
// - With bit 7 set and bit 6 set, D3hot stops the secondary clock.
// - With bit 7 set and bit 6 clear, D3hot removes secondary bus power.
`timescale 1ns/1ps
module pbpm_regs (
	input wire logic clk, // PCI clock
	input wire logic rst_n, // PCI reset, active low
	input wire logic cfg_wr, // Configuration write strobe
	input wire logic cfg_rd, // Configuration read strobe
	input wire logic [7:0] cfg_addr, // Configuration byte offset, dword aligned
	input wire logic [3:0] cfg_be, // Configuration byte enables
	input wire logic [31:0] cfg_wdata, // Configuration write data
	output logic [31:0] cfg_rdata, // Configuration read data
	output logic cfg_done, // Configuration access completed
	input wire logic loc_wr, // Local core write strobe
	input wire logic loc_rd, // Local core read strobe
	input wire logic [15:0] loc_addr, // Local core bus address
	input wire logic [3:0] loc_be, // Local core byte enables
	input wire logic [31:0] loc_wdata, // Local core write data
	output logic [31:0] loc_rdata, // Local core read data
	output logic loc_done, // Local core access completed
	output logic core_nmi, // Non-maskable interrupt pulse to the local core
	output logic sec_clk_run, // Secondary bus clock enable
	output logic sec_pwr_on // Secondary bus power enable
);
	import pbpm_pkg::*;

	localparam int NPORT = 2; // Port 0 is configuration space, port 1 the local core bus
	localparam int BSE_LSB = 16; // The bridge support byte rides in byte lane 2
	localparam logic [15:0] LOC_CSR_ADDR = PBPM_LOCAL_BASE | {8'h00, PBPM_OFF_CTRL_STATUS};

	// Stored register state
	logic [1:0] pstate_ff;
	logic secondary_pwr_clk_control_enable_ff;
	logic secondary_clock_stop_select_ff;
	logic change_pulse;

	// Both access ports as arrays, so the per-port decode is written once
	wire [NPORT-1:0] port_wr = {loc_wr, cfg_wr};
	wire [NPORT-1:0] port_rd = {loc_rd, cfg_rd};
	wire [NPORT-1:0] port_hit;
	wire [NPORT-1:0] port_wr_hit;
	wire [NPORT-1:0] port_rd_hit;
	wire [NPORT-1:0] port_busy;
	wire [3:0] port_be [NPORT];
	wire [31:0] port_wdata [NPORT];
	wire [31:0] port_rword [NPORT];
	wire [31:0] reg_word;

	assign port_hit[0] = (cfg_addr == PBPM_OFF_CTRL_STATUS);
	assign port_hit[1] = (loc_addr == LOC_CSR_ADDR);
	assign port_be[0] = cfg_be;
	assign port_be[1] = loc_be;
	assign port_wdata[0] = cfg_wdata;
	assign port_wdata[1] = loc_wdata;

	// Every strobe is answered, mapped or not, so an ignored write still completes
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		assign port_wr_hit[p] = port_wr[p] && port_hit[p];
		assign port_rd_hit[p] = port_rd[p] && port_hit[p];
		assign port_busy[p] = port_wr[p] || port_rd[p];
		assign port_rword[p] = port_rd_hit[p] ? reg_word : 32'h0000_0000;
	end

	// Config write wins a same-cycle collision, the local write is then lost
	wire cfg_wr_win = port_wr_hit[0];
	wire loc_wr_win = port_wr_hit[1] && !port_wr_hit[0];
	wire wr_any = cfg_wr_win || loc_wr_win;
	wire [3:0] be_sel = cfg_wr_win ? port_be[0] : port_be[1];
	wire [31:0] wd_sel = cfg_wr_win ? port_wdata[0] : port_wdata[1];

	// Power-state field in byte lane 0
	// Unsupported codes are dropped silently, the access itself still completes
	wire pstate_lane_wr = wr_any && be_sel[0];
	wire [1:0] req_state = wd_sel[1:0];
	wire req_is_d0 = (req_state == PBPM_PSTATE_D0);
	wire req_is_d3 = (req_state == PBPM_PSTATE_D3HOT);
	wire req_ok = req_is_d0 || req_is_d3;
	wire pstate_load = pstate_lane_wr && req_ok;
	wire [1:0] nxt_pstate = pstate_load ? req_state : pstate_ff;

	// Bridge support byte: only bits 7 and 6 are stored
	wire bse_wr = wr_any && be_sel[2];
	wire [7:0] bse_wbyte = wd_sel[BSE_LSB +: 8];
	wire nxt_secondary_pwr_clk_control_enable = bse_wr ? bse_wbyte[PBPM_BIT_SEC_PWR_CLK_CTL_EN] :
		secondary_pwr_clk_control_enable_ff;
	wire nxt_secondary_clock_stop_select = bse_wr ? bse_wbyte[PBPM_BIT_CLK_STOP_SEL] :
		secondary_clock_stop_select_ff;

	// Wake bits 15 and 8 and all reserved bits read as constant zero
	wire [15:0] csr_view = {1'b0, 6'h00, 1'b0, 6'h00, pstate_ff};
	wire [7:0] bse_view = {secondary_pwr_clk_control_enable_ff, secondary_clock_stop_select_ff, 6'h00};
	assign reg_word = {8'h00, bse_view, csr_view};

	// Secondary bus control only acts while the control enable is set
	wire in_d3 = (pstate_ff == PBPM_PSTATE_D3HOT);
	wire sec_ctl_d3 = secondary_pwr_clk_control_enable_ff && in_d3;
	wire sec_stop_clk = sec_ctl_d3 && secondary_clock_stop_select_ff;
	wire sec_cut_pwr = sec_ctl_d3 && !secondary_clock_stop_select_ff;
	wire nxt_sec_clk_run = !sec_stop_clk;
	wire nxt_sec_pwr_on = !sec_cut_pwr;

	// Registered answers: both ports reply one cycle after the strobe
	wire nxt_cfg_done = port_busy[0];
	wire [31:0] nxt_cfg_rdata = port_rword[0];
	wire nxt_loc_done = port_busy[1];
	wire [31:0] nxt_loc_rdata = port_rword[1];
	wire nxt_core_nmi = change_pulse;

	// Power state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pstate_ff <= PBPM_PSTATE_RESET;
		end else begin
			pstate_ff <= nxt_pstate;
		end
	end

	// Secondary bus power/clock control enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secondary_pwr_clk_control_enable_ff <= PBPM_BSE_RESET[PBPM_BIT_SEC_PWR_CLK_CTL_EN];
		end else begin
			secondary_pwr_clk_control_enable_ff <= nxt_secondary_pwr_clk_control_enable;
		end
	end

	// Clock-stop or power-cut select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secondary_clock_stop_select_ff <= PBPM_BSE_RESET[PBPM_BIT_CLK_STOP_SEL];
		end else begin
			secondary_clock_stop_select_ff <= nxt_secondary_clock_stop_select;
		end
	end

	// Config completion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_done <= 1'b0;
		end else begin
			cfg_done <= nxt_cfg_done;
		end
	end

	// Config read data, zero for unmapped offsets and for writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_rdata <= nxt_cfg_rdata;
		end
	end

	// Local completion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loc_done <= 1'b0;
		end else begin
			loc_done <= nxt_loc_done;
		end
	end

	// Local read data, zero for unmapped addresses and for writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loc_rdata <= 32'h0000_0000;
		end else begin
			loc_rdata <= nxt_loc_rdata;
		end
	end

	// Secondary clock runs again one cycle after the stored state leaves D3hot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_clk_run <= PBPM_SEC_ON_RESET;
		end else begin
			sec_clk_run <= nxt_sec_clk_run;
		end
	end

	// Secondary power returns one cycle after the stored state leaves D3hot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_pwr_on <= PBPM_SEC_ON_RESET;
		end else begin
			sec_pwr_on <= nxt_sec_pwr_on;
		end
	end

	// The detector watches the stored state, so a refused write never pulses
	pbpm_transition_detect u_detect (
		.clk(clk),
		.rst_n(rst_n),
		.state_now(pstate_ff),
		.change_pulse(change_pulse)
	);

	// Interrupt pulse to the local core
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_nmi <= 1'b0;
		end else begin
			core_nmi <= nxt_core_nmi;
		end
	end
endmodule // pbpm_regs

// File: hdl/pbpm_pkg.sv
// Package with offsets, field positions and reset values of the bridge power-management registers
package pbpm_pkg;
	localparam logic [7:0] PBPM_OFF_CTRL_STATUS = 8'h6c;
	localparam logic [7:0] PBPM_OFF_BRIDGE_SUPPORT = 8'h6e;
	localparam logic [15:0] PBPM_LOCAL_BASE = 16'h1000;
	localparam int PBPM_BIT_WAKE_FLAG = 15;
	localparam int PBPM_BIT_WAKE_ENABLE = 8;
	localparam int PBPM_BIT_SEC_PWR_CLK_CTL_EN = 7;
	localparam int PBPM_BIT_CLK_STOP_SEL = 6;
	localparam logic [1:0] PBPM_PSTATE_D0 = 2'h0;
	localparam logic [1:0] PBPM_PSTATE_D1 = 2'h1;
	localparam logic [1:0] PBPM_PSTATE_D2 = 2'h2;
	localparam logic [1:0] PBPM_PSTATE_D3HOT = 2'h3;
	localparam logic [1:0] PBPM_PSTATE_RESET = 2'h0;
	localparam logic [7:0] PBPM_BSE_RESET = 8'h00;
	localparam logic PBPM_SEC_ON_RESET = 1'b1;
	localparam int PBPM_NMI_PULSE_CYCLES = 1;
endpackage

// File: hdl/pbpm_transition_detect.sv
// Detector that turns a D0/D3hot power-state change into a one-cycle pulse
`timescale 1ns/1ps
module pbpm_transition_detect (
	input wire logic clk, // Clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [1:0] state_now, // Current stored power state
	output logic change_pulse // One-cycle pulse on a state change
);
	import pbpm_pkg::*;
	logic [1:0] prev_ff;
	wire changed = (prev_ff != state_now);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= PBPM_PSTATE_RESET;
			change_pulse <= 1'b0;
		end else begin
			prev_ff <= state_now;
			change_pulse <= changed;
		end
	end
endmodule // pbpm_transition_detect

// File: test/pbpm_regs_checker.sv
// Checker for the bridge power-management register ports
`timescale 1ns/1ps
module pbpm_regs_checker import pbpm_pkg::*; (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic cfg_wr, // Config write strobe
	input wire logic cfg_rd, // Config read strobe
	input wire logic [7:0] cfg_addr, // Config offset
	input wire logic [31:0] cfg_rdata, // Config read data
	input wire logic cfg_done, // Config completion
	input wire logic loc_wr, // Local write strobe
	input wire logic loc_rd, // Local read strobe
	input wire logic loc_done, // Local completion
	input wire logic core_nmi, // Interrupt pulse
	input wire logic sec_clk_run, // Secondary clock enable
	input wire logic sec_pwr_on // Secondary power enable
);
	default clocking cbk @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_cdone; cfg_wr || cfg_rd |=> cfg_done; endproperty
	a_cdone: assert property (p_cdone) else $error("config access not completed");
	property p_ldone; loc_wr || loc_rd |=> loc_done; endproperty
	a_ldone: assert property (p_ldone) else $error("local access not completed");
	property p_unmap; cfg_rd && cfg_addr != PBPM_OFF_CTRL_STATUS |=> cfg_rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_wake; cfg_done |-> !cfg_rdata[15] && !cfg_rdata[8]; endproperty
	a_wake: assert property (p_wake) else $error("wake bits not zero");
	property p_rsv; cfg_done |-> (cfg_rdata & 32'hff3f_7efc) == 32'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	property p_state; cfg_done |-> cfg_rdata[1:0] inside {2'h0, 2'h3}; endproperty
	a_state: assert property (p_state) else $error("unsupported state stored");
	property p_nmi; core_nmi |-> $past(cfg_done, 2) || $past(loc_done, 2); endproperty
	a_nmi: assert property (p_nmi) else $error("interrupt without write");
	property p_sec; $changed(sec_pwr_on) || $changed(sec_clk_run) |-> $past(cfg_done) || $past(loc_done); endproperty
	a_sec: assert property (p_sec) else $error("secondary bus changed without write");
	c_nmi: cover property (core_nmi);
	c_clk: cover property (!sec_clk_run);
	c_pwr: cover property (!sec_pwr_on);
endmodule // pbpm_regs_checker

// File: test/pbpm_host.sv
// Access master model for the configuration or local port
`timescale 1ns/1ps
module pbpm_host #(parameter int AW = 8) (
	input wire logic clk, // Clock
	output logic wr, // Write strobe
	output logic rd, // Read strobe
	output logic [AW-1:0] addr, // Address
	output logic [3:0] be, // Byte enables
	output logic [31:0] wdata, // Write data
	input wire logic [31:0] rdata, // Read data
	input wire logic done // Completion
);
	initial {wr, rd, addr, be, wdata} = '0;
	task automatic acc(input logic w, input logic [AW-1:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic dn);
		@(posedge clk);
		{wr, rd, addr, be, wdata} <= {w, !w, a, 4'hf, d};
		@(posedge clk);
		{wr, rd, addr, be, wdata} <= {2'h0, ~a, 4'h0, ~d}; // Released lines stop showing old values
		#1 {q, dn} = {rdata, done};
	endtask
endmodule // pbpm_host

// File: test/tb_top.sv
// Self-checking bench for the bridge power-management registers
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_n = 0, cw, cr, lw, lr, cd, ld, nmi, scr, spo, dn, dn2;
	logic [3:0] cb, lb;
	logic [7:0] ca;
	logic [15:0] la;
	logic [31:0] cwd, crd, lwd, lrd, q, q2;
	int n_fail = 0, samples_checked = 0, n_nmi = 0, cyc = 0;
	pbpm_regs DUT (.clk(clk), .rst_n(rst_n), .cfg_wr(cw), .cfg_rd(cr), .cfg_addr(ca), .cfg_be(cb), .cfg_wdata(cwd),
		.cfg_rdata(crd), .cfg_done(cd), .loc_wr(lw), .loc_rd(lr), .loc_addr(la), .loc_be(lb), .loc_wdata(lwd),
		.loc_rdata(lrd), .loc_done(ld), .core_nmi(nmi), .sec_clk_run(scr), .sec_pwr_on(spo));
	pbpm_host h (.clk(clk), .wr(cw), .rd(cr), .addr(ca), .be(cb), .wdata(cwd), .rdata(crd), .done(cd));
	pbpm_host #(.AW(16)) c (.clk(clk), .wr(lw), .rd(lr), .addr(la), .be(lb), .wdata(lwd), .rdata(lrd), .done(ld));
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		n_nmi <= n_nmi + nmi;
		cyc <= cyc + 1;
		if (cyc == 500) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		h.acc(w, a, d, q, dn);
		chk("cfg_done", 1, dn);
		if (!w) chk("cfg_rdata", e, q);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		cf(0, 8'h6c, 0, 0);
		cf(1, 8'h6c, 32'hffff_ffff, 0);
		cf(0, 8'h6c, 0, 32'h00c0_0003);
		chk("sec", 2'b01, {scr, spo});
		for (int v = 1; v < 3; v++) cf(1, 8'h6c, 32'h00c0_0000 | v, 0);
		cf(0, 8'h6c, 0, 32'h00c0_0003);
		c.acc(1, 16'h106c, 32'h0080_0000, q, dn);
		chk("loc_done", 1, dn);
		cf(0, 8'h6c, 0, 32'h0080_0000);
		chk("sec", 2'b11, {scr, spo});
		cf(1, 8'h6c, 32'h0080_0003, 0);
		c.acc(0, 16'h106c, 0, q, dn);
		chk("loc_rdata", 32'h0080_0003, q);
		chk("sec", 2'b10, {scr, spo});
		cf(0, 8'h70, 0, 0);
		fork
			h.acc(1, 8'h6c, 32'h0080_0003, q, dn);
			c.acc(1, 16'h106c, 32'h0000_0000, q2, dn2);
		join
		chk("loc_done", 1, dn2);
		cf(0, 8'h6c, 0, 32'h0080_0003);
		chk("nmi", 3, n_nmi);
		@(posedge clk);
		rst_n <= 0;
		@(posedge clk);
		rst_n <= 1;
		chk("sec", 2'b11, {scr, spo});
		cf(0, 8'h6c, 0, 0);
		finish_test();
	end
endmodule // tb_top
bind pbpm_regs pbpm_regs_checker u_chk (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
	.cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .loc_wr(loc_wr), .loc_rd(loc_rd),
	.loc_done(loc_done), .core_nmi(core_nmi), .sec_clk_run(sec_clk_run), .sec_pwr_on(sec_pwr_on));
